// [bench/branch_and_operand_address_gen_bench.sv]
// Self-checking bench for the branch and operand address generator.
// Assumes only the design's top module and package; the bench plays the table memory.
`timescale 1ns/1ps
`default_nettype none

module branch_and_operand_address_gen_bench
    import addr_gen_pkg::*;
();
    logic               sys_clk = 1'b0;
    logic               rst;
    instr_request_type  req;
    logic               op_ready;
    logic [1:0]         bank_sel;
    logic [15:0]        accumulator_pair;
    logic               reg_bank_sel_bit0;
    logic               reg_bank_sel_bit1;
    logic [15:0]        pc;
    logic [17:0]        fetch_addr;
    logic [15:0]        return_addr;
    logic               pc_loaded;
    operand_select_type operand_sel;
    logic               mem_rd_req;
    logic [15:0]        mem_rd_addr;
    logic [7:0]         mem_rd_data;
    int                 failures = 0;
    int                 total_checks = 0;
    int                 cycle_count = 0;
    int                 seed = 32'h158fe5a2;
    logic [15:0]        ret_model = 16'h0000;
    logic [15:0]        pc_model = 16'h0000;
    op_kind_type        corner_kind [17] = '{op_rel_branch, op_rel_branch, op_cond_branch,
        op_cond_branch, op_abs_branch, op_abs_call, op_short_fixed_call, op_short_fixed_call,
        op_table_call, op_table_call, op_pair_jump, op_unsigned_multiply, op_unsigned_word_divide,
        op_decimal_adjust_add, op_decimal_adjust_sub, op_digit_rotate_left, op_digit_rotate_right};
    logic [15:0]        corner_field [17] = '{16'h0080, 16'h007f, 16'h80fe, 16'h0005, 16'hffff,
        16'h1234, 16'h0000, 16'h07ff, 16'h00c1, 16'h00be, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000};

    branch_and_operand_address_gen i_branch_and_operand_address_gen (
        .sys_clk(sys_clk), .rst(rst), .req(req), .op_ready(op_ready), .bank_sel(bank_sel),
        .accumulator_pair(accumulator_pair), .reg_bank_sel_bit0(reg_bank_sel_bit0),
        .reg_bank_sel_bit1(reg_bank_sel_bit1), .pc(pc), .fetch_addr(fetch_addr),
        .return_addr(return_addr), .pc_loaded(pc_loaded), .operand_sel(operand_sel),
        .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data));

    // ==========================================================================
    // Clock, table memory and hang guard
    always #12.5 sys_clk = ~sys_clk;

    // The byte pattern depends on every bit of the low address byte, so a wrong entry shows up.
    function automatic logic [7:0] tbl(input logic [15:0] a);
        return a[7:0] ^ {a[3:0], a[7:4]} ^ 8'h5a;
    endfunction : tbl

    always @(posedge sys_clk) mem_rd_data <= tbl(mem_rd_addr);

    always @(posedge sys_clk) begin
        cycle_count++;
        if (cycle_count == 8000) begin
            failures++;
            $display("mismatch at %0t: run did not finish", $time);
            give_verdict();
        end
    end

    // ==========================================================================
    // Expectations
    function automatic logic [15:0] entry_of(input instr_request_type r);
        return TABLE_BASE + {10'h000, r.opcode[5:1], 1'b0};
    endfunction : entry_of

    function automatic logic [15:0] next_pc(input instr_request_type r, input logic [15:0] p,
                                            input logic [15:0] acc);
        logic [15:0] seq;
        logic [15:0] rel;
        seq = p + {13'h0000, r.instr_len};
        rel = seq + {{8{r.branch_displacement[7]}}, r.branch_displacement};
        case (r.op_kind)
            op_rel_branch:              return rel;
            op_cond_branch:             return r.cond_taken ? rel : seq;
            op_abs_branch, op_abs_call: return r.absolute_target;
            op_short_fixed_call:        return FIXED_BASE | {5'h00, r.short_call_target};
            op_table_call:              return {tbl(entry_of(r) + 16'h0001), tbl(entry_of(r))};
            op_pair_jump:               return acc;
            default:                    return seq;
        endcase
    endfunction : next_pc

    function automatic instr_request_type mk(input op_kind_type k, input logic [2:0] len,
                                             input logic [15:0] f);
        instr_request_type r;
        r = '0;
        r.valid = 1'b1;
        r.op_kind = k;
        r.instr_len = len;
        r.cond_taken = f[15];
        r.branch_displacement = f[7:0];
        r.absolute_target = f;
        r.short_call_target = f[10:0];
        r.opcode = f[7:0];
        r.reg_code = f[2:0];
        r.pair_code = f[4:3];
        return r;
    endfunction : mk

    // ==========================================================================
    // Compare tasks
    task automatic check_addr(input logic [17:0] got, input logic [17:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : check_addr

    task automatic check_flag(input logic got, input logic exp, input string m);
        check_addr({17'h00000, got}, {17'h00000, exp}, m);
    endtask : check_flag

    task automatic check_sel(input logic by, input logic pr, input logic [2:0] code,
                             input logic [1:0] pc2, input logic [1:0] bk, input logic pk);
        check_flag(operand_sel.byte_used, by, "byte used");
        if (by) check_addr({13'h0, operand_sel.byte_index}, {13'h0, bk, code}, "byte index");
        if (by) check_addr({15'h0, operand_sel.byte_code}, {15'h0, code}, "byte code");
        if (pk) check_flag(operand_sel.pair_used, pr, "pair used");
        if (pk && pr) check_addr({14'h0, operand_sel.pair_index}, {14'h0, bk, pc2}, "pair index");
    endtask : check_sel

    // ==========================================================================
    // One instruction: issue, wait for the load, compare pc, fetch and return addresses and any implied or register operands
    task automatic run_op(input instr_request_type r, input int hold);
        logic [15:0] acc;
        logic [1:0]  bk;
        logic [15:0] exp_pc;
        logic        tab;
        int          cycles;
        acc = 16'($random(seed));
        bk = 2'($random(seed));
        tab = (r.op_kind == op_table_call);
        exp_pc = next_pc(r, pc_model, acc);
        if (r.op_kind inside {op_abs_call, op_short_fixed_call, op_table_call})
            ret_model = pc_model + {13'h0000, r.instr_len};
        @(posedge sys_clk);
        req <= r;
        accumulator_pair <= acc;
        {reg_bank_sel_bit1, reg_bank_sel_bit0} <= bk;
        // The bank is set together with the request, so no fetch ever sees a stale bank.
        bank_sel <= 2'($random(seed));
        @(posedge sys_clk);
        cycles = 1;
        if (hold == 0) req.valid <= 1'b0;
        #1;
        check_flag(op_ready, !tab, "ready after accept");
        check_flag(mem_rd_req, tab, "table read request");
        if (tab) check_addr({2'b00, mem_rd_addr}, {2'b00, entry_of(r)}, "entry address");
        repeat (hold) begin
            @(posedge sys_clk);
            cycles++;
            #1;
            check_flag(op_ready, 1'b0, "refused while busy");
        end
        if (hold != 0) req.valid <= 1'b0;
        #1;
        while (pc_loaded !== 1'b1 && cycles < 10) begin
            @(posedge sys_clk);
            #1;
            cycles++;
        end
        check_addr(18'(cycles), tab ? 18'd4 : 18'd1, "load latency");
        check_addr({2'b00, pc}, {2'b00, exp_pc}, "pc");
        check_addr(fetch_addr, {bank_sel, exp_pc}, "fetch address");
        check_addr({2'b00, return_addr}, {2'b00, ret_model}, "return address");
        if (tab) check_addr({2'b00, mem_rd_addr}, {2'b00, entry_of(r) + 16'h0001}, "high byte");
        pc_model = exp_pc;
        case (r.op_kind)
            op_unsigned_multiply:
                check_sel(1'b1, 1'b1, REG_A, PAIR_ACCUMULATOR, bk, 1'b1);
            op_unsigned_word_divide:
                check_sel(1'b0, 1'b1, REG_A, PAIR_ACCUMULATOR, bk, 1'b1);
            op_decimal_adjust_add, op_decimal_adjust_sub:
                check_sel(1'b1, 1'b0, REG_A, 2'h0, bk, 1'b1);
            op_digit_rotate_left, op_digit_rotate_right:
                check_sel(1'b1, 1'b0, REG_A, 2'h0, bk, 1'b1);
            op_register:
                check_sel(1'b1, 1'b1, r.reg_code, r.pair_code, bk, 1'b1);
            default: ;
        endcase
    endtask : run_op

    task automatic check_reset();
        check_addr({2'b00, pc}, {2'b00, RESET_PC}, "pc after reset");
        check_addr({2'b00, return_addr}, {2'b00, RESET_PC}, "return after reset");
        check_addr({2'b00, mem_rd_addr}, {2'b00, TABLE_BASE}, "read address after reset");
        check_addr({2'b00, operand_sel}, 18'h00000, "operands after reset");
        check_flag(op_ready, 1'b1, "ready after reset");
        check_flag(mem_rd_req, 1'b0, "no read after reset");
        check_flag(pc_loaded, 1'b0, "no load after reset");
        pc_model = RESET_PC;
        ret_model = RESET_PC;
    endtask : check_reset

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    // ==========================================================================
    // Main sequence: reset, corner cases, then random traffic
    initial begin
        rst = 1'b1;
        req = '0;
        bank_sel = 2'h0;
        accumulator_pair = 16'h0000;
        reg_bank_sel_bit0 = 1'b0;
        reg_bank_sel_bit1 = 1'b0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        check_reset();
        for (int i = 0; i < 17; i++)
            run_op(mk(corner_kind[i], 3'(i % 4 + 1), corner_field[i]), (i == 9) ? 2 : 0);
        // A reset in mid-run must bring every register back to its reset value.
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        check_reset();
        for (int c = 0; c < 8; c++)
            run_op(mk(op_register, 3'h2, 16'(c)), 0);
        for (int n = 0; n < 300; n++)
            run_op(mk(op_kind_type'({$random(seed)} % 15), 3'({$random(seed)} % 4 + 1),
                      16'($random(seed))), 0);
        give_verdict();
    end
endmodule : branch_and_operand_address_gen_bench

`default_nettype wire

// [hdl/addr_gen_pkg.sv]
// Constants, enumerations and carriers for the branch and operand address generator.
// Assumes a single CPU clock domain and a synchronous active-high reset.
package addr_gen_pkg;

    localparam int unsigned PC_WIDTH    = 16;
    localparam logic [15:0] RESET_PC    = 16'h0000;
    localparam logic [15:0] TABLE_BASE  = 16'h0040;
    localparam logic [15:0] TABLE_LAST  = 16'h007f;
    localparam logic [15:0] FIXED_BASE  = 16'h0800;
    localparam logic [15:0] FIXED_LAST  = 16'h0fff;
    localparam int unsigned INDEX_LSB   = 1;
    localparam int unsigned INDEX_MSB   = 5;

    localparam logic [2:0] REG_X = 3'h0;
    localparam logic [2:0] REG_A = 3'h1;
    localparam logic [2:0] REG_C = 3'h2;
    localparam logic [2:0] REG_B = 3'h3;
    localparam logic [2:0] REG_E = 3'h4;
    localparam logic [2:0] REG_D = 3'h5;
    localparam logic [2:0] REG_L = 3'h6;
    localparam logic [2:0] REG_H = 3'h7;

    localparam logic [1:0] PAIR_ACCUMULATOR = 2'h0;
    localparam logic [1:0] PAIR_BC          = 2'h1;
    localparam logic [1:0] PAIR_DE          = 2'h2;
    localparam logic [1:0] PAIR_HL          = 2'h3;

    typedef enum logic [3:0] {
        op_sequential,
        op_rel_branch,
        op_cond_branch,
        op_abs_branch,
        op_abs_call,
        op_short_fixed_call,
        op_table_call,
        op_pair_jump,
        op_unsigned_multiply,
        op_unsigned_word_divide,
        op_decimal_adjust_add,
        op_decimal_adjust_sub,
        op_digit_rotate_left,
        op_digit_rotate_right,
        op_register
    } op_kind_type;

    typedef struct packed {
        logic        valid;
        op_kind_type op_kind;
        logic [2:0]  instr_len;
        logic        cond_taken;
        logic [7:0]  branch_displacement;
        logic [15:0] absolute_target;
        logic [10:0] short_call_target;
        logic [7:0]  opcode;
        logic [2:0]  reg_code;
        logic [1:0]  pair_code;
    } instr_request_type;

    typedef struct packed {
        logic       byte_used;
        logic [4:0] byte_index;
        logic [2:0] byte_code;
        logic       pair_used;
        logic [3:0] pair_index;
        logic [1:0] pair_code;
    } operand_select_type;

endpackage : addr_gen_pkg

// [hdl/branch_and_operand_address_gen.sv]
// Next-instruction address and branch target generation with operand register selection.
// Assumes the table memory answers a read one clock after the request, and that
// the bank selection, accumulator pair and flags come from logic on sys_clk.
`timescale 1ns/1ps
`default_nettype none

module branch_and_operand_address_gen
    import addr_gen_pkg::*;
#(
    parameter int unsigned BANK_WIDTH = 2
)
(
    input  wire logic                           sys_clk,
    input  wire logic                           rst,
    input  wire instr_request_type              req,
    output logic                                op_ready,
    input  wire logic [BANK_WIDTH-1:0]          bank_sel,
    input  wire logic [15:0]                    accumulator_pair,
    input  wire logic                           reg_bank_sel_bit0,
    input  wire logic                           reg_bank_sel_bit1,
    output logic [15:0]                         pc,
    output logic [BANK_WIDTH+15:0]              fetch_addr,
    output logic [15:0]                         return_addr,
    output logic                                pc_loaded,
    output operand_select_type                  operand_sel,
    output logic                                mem_rd_req,
    output logic [15:0]                         mem_rd_addr,
    input  wire logic [7:0]                     mem_rd_data
);

    // ==========================================================
    // Target computation
    // ==========================================================
    typedef enum logic [1:0] {
        st_idle,
        st_table_low,
        st_table_high,
        st_table_load
    } seq_state_type;

    seq_state_type       state;
    logic [7:0]          table_low;
    operand_select_type  next_operand;

    wire        accept      = req.valid && op_ready;
    wire [15:0] seq_pc      = pc + {13'h0000, req.instr_len};
    wire [15:0] disp_ext    = {{8{req.branch_displacement[7]}},
                               req.branch_displacement};
    wire [15:0] rel_pc      = seq_pc + disp_ext;
    wire [15:0] fixed_pc    = FIXED_BASE | {5'h00, req.short_call_target};
    wire [4:0]  table_index = req.opcode[INDEX_MSB:INDEX_LSB];
    wire [15:0] table_entry = TABLE_BASE + {10'h000, table_index, 1'b0};
    wire        is_call     = (req.op_kind == op_abs_call) ||
                              (req.op_kind == op_short_fixed_call) ||
                              (req.op_kind == op_table_call);

    logic [15:0] next_pc;

    always_comb begin
        case (req.op_kind)
            op_rel_branch:       next_pc = rel_pc;
            op_cond_branch:      next_pc = req.cond_taken ? rel_pc : seq_pc;
            op_abs_branch,
            op_abs_call:         next_pc = req.absolute_target;
            op_short_fixed_call: next_pc = fixed_pc;
            op_pair_jump:        next_pc = accumulator_pair;
            op_table_call:       next_pc = pc;
            default:             next_pc = seq_pc;
        endcase
    end

    operand_reg_select i_operand_reg_select (
        .reg_bank_sel_bit0 (reg_bank_sel_bit0),
        .reg_bank_sel_bit1 (reg_bank_sel_bit1),
        .op_kind           (req.op_kind),
        .reg_code          (req.reg_code),
        .pair_code         (req.pair_code),
        .sel               (next_operand)
    );

    // ==========================================================
    // Handshake and address outputs
    // ==========================================================
    // The bank is taken live so a bank write lands on the very next fetch.
    assign fetch_addr = {bank_sel, pc};
    assign op_ready   = (state == st_idle);
    assign mem_rd_req = (state == st_table_low) || (state == st_table_high);

    // ==========================================================
    // Sequencer
    // ==========================================================
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state       <= st_idle;
            pc          <= RESET_PC;
            return_addr <= RESET_PC;
            pc_loaded   <= 1'b0;
            table_low   <= 8'h00;
            mem_rd_addr <= TABLE_BASE;
            operand_sel <= '0;
        end else begin
            pc_loaded <= 1'b0;
            case (state)
                st_idle: begin
                    if (accept) begin
                        operand_sel <= next_operand;
                        if (is_call) begin
                            return_addr <= seq_pc;
                        end
                        if (req.op_kind == op_table_call) begin
                            mem_rd_addr <= table_entry;
                            state       <= st_table_low;
                        end else begin
                            pc        <= next_pc;
                            pc_loaded <= 1'b1;
                        end
                    end
                end
                st_table_low: begin
                    mem_rd_addr <= mem_rd_addr + 16'h0001;
                    state       <= st_table_high;
                end
                st_table_high: begin
                    table_low <= mem_rd_data;
                    state     <= st_table_load;
                end
                st_table_load: begin
                    pc        <= {mem_rd_data, table_low};
                    pc_loaded <= 1'b1;
                    state     <= st_idle;
                end
                default: begin
                    state <= st_idle;
                end
            endcase
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_seq_advance: assert property (
        accept && req.op_kind == op_sequential |=> pc == $past(pc) + 16'($past(req.instr_len)))
        else $error("Sequential advance wrong.");

    a_rel_target: assert property (
        accept && req.op_kind == op_rel_branch
        |=> pc == 16'($past(pc) + 16'($past(req.instr_len))
                  + {{8{$past(req.branch_displacement[7])}}, $past(req.branch_displacement)}))
        else $error("Relative target wrong.");

    a_cond_not_taken: assert property (
        accept && req.op_kind == op_cond_branch && !req.cond_taken
        |=> pc == $past(pc) + 16'($past(req.instr_len)))
        else $error("Untaken branch did not fall through.");

    a_abs_target: assert property (
        accept && (req.op_kind == op_abs_branch || req.op_kind == op_abs_call)
        |=> pc == $past(req.absolute_target) && pc_loaded)
        else $error("Absolute target not loaded.");

    a_fixed_range: assert property (
        accept && req.op_kind == op_short_fixed_call
        |=> pc >= FIXED_BASE && pc <= FIXED_LAST && pc[10:0] == $past(req.short_call_target))
        else $error("Short call left fixed area.");

    a_table_reads: assert property (
        accept && req.op_kind == op_table_call
        |=> mem_rd_req && mem_rd_addr == TABLE_BASE + {10'h000, $past(req.opcode[5:1]), 1'b0}
        ##1 mem_rd_req && mem_rd_addr == $past(mem_rd_addr) + 16'h0001
            && mem_rd_addr <= TABLE_LAST)
        else $error("Table entry address wrong.");

    a_table_load: assert property (
        state == st_table_high ##1 state == st_table_load
        |=> pc_loaded && pc == {$past(mem_rd_data), $past(mem_rd_data, 2)} && op_ready)
        else $error("Table destination not loaded.");

    a_pair_jump: assert property (
        accept && req.op_kind == op_pair_jump |=> pc == $past(accumulator_pair))
        else $error("Pair jump target wrong.");

    a_fetch_bank: assert property (
        fetch_addr[15:0] == pc && fetch_addr[BANK_WIDTH+15:16] == bank_sel)
        else $error("Fetch address not bank and counter.");

    a_implied_mul: assert property (
        accept && req.op_kind == op_unsigned_multiply
        |=> operand_sel.byte_code == REG_A && operand_sel.pair_code == PAIR_ACCUMULATOR
            && operand_sel.byte_used && operand_sel.pair_used)
        else $error("Multiply operands not implied.");

    a_reg_select: assert property (
        accept && req.op_kind == op_register
        |=> operand_sel.byte_index == {$past(reg_bank_sel_bit1), $past(reg_bank_sel_bit0),
                                       $past(req.reg_code)})
        else $error("Register selection wrong.");

    a_call_return: assert property (
        accept && is_call |=> return_addr == 16'($past(pc) + 16'($past(req.instr_len))))
        else $error("Return address not next instruction.");

    a_table_busy: assert property (
        accept && req.op_kind == op_table_call
        |=> !op_ready ##1 !op_ready ##1 !op_ready && !mem_rd_req)
        else $error("Table call did not hold off requests.");

    a_implied_divide: assert property (
        accept && req.op_kind == op_unsigned_word_divide
        |=> operand_sel.pair_used && !operand_sel.byte_used
            && operand_sel.pair_code == PAIR_ACCUMULATOR)
        else $error("Divide operand not implied.");

    a_implied_accum: assert property (
        accept && req.op_kind inside {op_decimal_adjust_add, op_decimal_adjust_sub,
                                      op_digit_rotate_left, op_digit_rotate_right}
        |=> operand_sel.byte_used && operand_sel.byte_code == REG_A && !operand_sel.pair_used)
        else $error("Accumulator operand not implied.");

    c_table_call: cover property (accept && req.op_kind == op_table_call ##3 pc_loaded);
    c_rel_back:   cover property (accept && req.op_kind == op_rel_branch
                                  && req.branch_displacement[7]);
    c_cond_taken: cover property (accept && req.op_kind == op_cond_branch && req.cond_taken);
    c_pair_jump:  cover property (accept && req.op_kind == op_pair_jump);

endmodule : branch_and_operand_address_gen

`default_nettype wire

// [hdl/operand_reg_select.sv]
// Operand register selection for implied and register addressing.
// Assumes bank select flags and request fields are stable in the cycle they are used.
`timescale 1ns/1ps
`default_nettype none

module operand_reg_select
    import addr_gen_pkg::*;
(
    input  wire logic               reg_bank_sel_bit0,
    input  wire logic               reg_bank_sel_bit1,
    input  wire op_kind_type        op_kind,
    input  wire logic [2:0]         reg_code,
    input  wire logic [1:0]         pair_code,
    output operand_select_type      sel
);

    logic [2:0] byte_code;
    logic [1:0] pr_code;
    logic       byte_used;
    logic       pair_used;

    wire  [1:0] bank = {reg_bank_sel_bit1, reg_bank_sel_bit0};

    always_comb begin
        byte_code = REG_A;
        pr_code   = PAIR_ACCUMULATOR;
        byte_used = 1'b0;
        pair_used = 1'b0;
        case (op_kind)
            op_unsigned_multiply: begin
                byte_used = 1'b1;
                pair_used = 1'b1;
            end
            op_unsigned_word_divide: begin
                pair_used = 1'b1;
            end
            op_decimal_adjust_add, op_decimal_adjust_sub: begin
                byte_used = 1'b1;
            end
            op_digit_rotate_left, op_digit_rotate_right: begin
                byte_used = 1'b1;
            end
            op_register: begin
                byte_code = reg_code;
                pr_code   = pair_code;
                byte_used = 1'b1;
                pair_used = 1'b1;
            end
            default: begin
                byte_used = 1'b0;
            end
        endcase
    end

    // Eight byte registers and four pairs per bank, so the bank forms the upper bits.
    assign sel.byte_used  = byte_used;
    assign sel.byte_code  = byte_code;
    assign sel.byte_index = {bank, byte_code};
    assign sel.pair_used  = pair_used;
    assign sel.pair_code  = pr_code;
    assign sel.pair_index = {bank, pr_code};

endmodule : operand_reg_select

`default_nettype wire
